// file: logic/csp_pkg.sv
// Constants for the codec serial port and compander block
// Contract
// - Lower control bit 10 is a latch driving the user flag pin.
// - Serial path enable selects serial companding or parallel companding mode.
// - Writing 1 to a flag bit on port 0 clears it; 0 leaves it.
// - Frame counter modulus works the same with external or internal bit clock.
// - The 16-bit lower control register is read and written at port 0.
// - Port1 select bit 0 reaches upper control; 1 reaches data paths.
// - Two receive and two transmit 8-bit data registers sit behind port 1.
// - Transfers are framed by the internal sync or by external sync inputs.
// - An external bit clock times all serial bits and frame sync.
// - An internal bit clock divides the master clock by the prescale field.
// - Prescale decode: 32,28,24,20,16,14,12,10 by field pattern.
// - Internal sync rate comes from counting bit clocks per the divider field.
// - Law select 0 chooses mu-255 law and 1 chooses A-law.
// - Serial encoder compresses linear PCM into the transmit register.
// - Serial decoder expands a received 8-bit code to linear PCM.
// - Parallel encode takes a 14-bit value and returns the code on read.
// - Parallel decode takes an 8-bit code and returns linear on next read.
// - Internal sync rate is bit clock over divider value plus 2.
// - Ext sync select 0 uses internal sync; 1 uses external sync inputs.
// - Sync width select 0 gives one bit clock pulse; 1 gives eight.
// - Compress and expand enables turn conversion of port 1 data on or off.
package csp_pkg;
  localparam int unsigned PORT_LOWER = 0;
  localparam int unsigned PORT_UPPER = 1;
  localparam logic [15:0] LOWER_RST = 16'h0000;
  localparam logic [12:0] UPPER_RST = 13'h0000;
  localparam int unsigned B_FLAG_INT = 0;
  localparam int unsigned B_FLAG_RXS = 1;
  localparam int unsigned B_FLAG_TXS = 2;
  localparam int unsigned B_FLAG_SYN = 3;
  localparam int unsigned B_PORT1_SEL = 8;
  localparam int unsigned B_EXT_SYNC = 9;
  localparam int unsigned B_USER_FLAG = 10;
  localparam int unsigned B_SERIAL_EN = 11;
  localparam int unsigned B_COMPRESS = 12;
  localparam int unsigned B_EXPAND = 13;
  localparam int unsigned B_LAW = 14;
  localparam int unsigned B_CLK_IN = 15;
  localparam int unsigned U_DIV_LO = 0;
  localparam int unsigned U_PRE_LO = 8;
  localparam int unsigned U_WIDTH = 12;
  localparam logic [7:0] SYNC_DIV_OFFSET = 8'h02;
  localparam logic [3:0] WIDE_PULSE_BITS = 4'h8;
  localparam logic [13:0] MU_BIAS = 14'h0021;
endpackage

// file: logic/csp_top.sv
// Codec serial port with frame counter, prescaler and compander
`timescale 1ns/1ps
module csp_top #(
  parameter int unsigned SAMPLE_W = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [2:0] port_addr,
  input wire logic port_wr,
  input wire logic port_rd,
  input wire logic [15:0] port_wdata,
  output logic [15:0] port_rdata,
  input wire logic master_clock_input,
  input wire logic bitclk_in,
  output logic bitclk_out,
  output logic bitclk_oe,
  input wire logic ext_int_n,
  input wire logic ext_rx_sync_n,
  input wire logic ext_tx_sync_n,
  input wire logic [1:0] ser_rx,
  output logic [1:0] ser_tx,
  output logic internal_sync_pulse,
  output logic user_flag_pin
);
  logic [15:0] lower_control_r;
  logic [12:0] upper_control_r;
  logic [15:0] port_rdata_r;
  logic [2:0] mck_s_r, bck_s_r, int_s_r, rxs_s_r, txs_s_r;
  logic [1:0] rx0_s_r, rx1_s_r;
  logic mck_st_r, bck_st_r, int_st_r, rxs_st_r, txs_st_r, rx0_st_r, rx1_st_r;
  logic [4:0] pre_cnt_r;
  logic bitclk_gen_r;
  logic bclk_prev_r;
  logic [7:0] frame_cnt_r;
  logic [3:0] pulse_cnt_r;
  logic sync_r;
  logic [3:0] bit_cnt_r;
  logic active_r;
  logic [SAMPLE_W-1:0] tx_data_r [2];
  logic [SAMPLE_W-1:0] rx_data_r [2];
  logic [SAMPLE_W-1:0] tx_sh_r [2];
  logic [SAMPLE_W-1:0] rx_sh_r [2];
  logic [15:0] par_result_r;
  logic ch_sel_r;
  logic mck_rise, bclk, bclk_rise, bclk_fall, frame_start, int_fire, rxs_fire, txs_fire;
  logic wr0, wr1, rd1, data_path;
  logic [5:0] pre_ratio;

  // Prescale divide ratio
  function automatic logic [5:0] pre_decode(input logic [3:0] f);
    casez (f)
      4'b0000: pre_decode = 6'h20;
      4'b0001: pre_decode = 6'h1C;
      4'b001?: pre_decode = 6'h18;
      4'b01??: pre_decode = 6'h14;
      4'b1000: pre_decode = 6'h10;
      4'b1001: pre_decode = 6'h0E;
      4'b101?: pre_decode = 6'h0C;
      default: pre_decode = 6'h0A;
    endcase
  endfunction

  // Linear sign-magnitude to 8-bit log code; A-law mag uses 12 bits
  function automatic logic [7:0] encode(input logic [13:0] lin, input logic alaw);
    logic [12:0] mag;
    logic [2:0] seg;
    logic [3:0] mant;
    mag = lin[12:0];
    seg = 3'h0;
    mant = 4'h0;
    if (alaw) begin
      mag = {1'b0, lin[11:0]};
      seg = 3'h0;
      for (int i = 11; i >= 5; i--) begin
        if (seg == 3'h0 && mag[i]) begin
          seg = 3'(i - 4);
        end
      end
      mant = (seg == 3'h0) ? mag[4:1] : 4'(mag >> seg);
      encode = {lin[13], seg, mant} ^ 8'h55;
    end else begin
      for (int i = 12; i >= 6; i--) begin
        if (seg == 3'h0 && mag[i]) begin
          seg = 3'(i - 5);
        end
      end
      mant = 4'(mag >> ({1'b0, seg} + 4'h1));
      encode = ~{lin[13], seg, mant};
    end
  endfunction

  // 8-bit log code to linear sign-magnitude
  function automatic logic [13:0] decode(input logic [7:0] code, input logic alaw);
    logic [7:0] c;
    logic [12:0] mag;
    c = alaw ? (code ^ 8'h55) : ~code;
    mag = 13'h0000;
    if (alaw) begin
      if (c[6:4] == 3'h0) begin
        mag = {8'h00, c[3:0], 1'b1};
      end else begin
        mag = 13'({1'b1, c[3:0], 1'b1}) << (c[6:4] - 3'h1);
      end
    end else begin
      mag = 13'({1'b1, c[3:0], 1'b1}) << c[6:4];
    end
    decode = {c[7], mag};
  endfunction

  assign wr0 = port_wr && port_addr == 3'(csp_pkg::PORT_LOWER);
  assign wr1 = port_wr && port_addr == 3'(csp_pkg::PORT_UPPER);
  assign rd1 = port_rd && port_addr == 3'(csp_pkg::PORT_UPPER);
  assign data_path = lower_control_r[csp_pkg::B_PORT1_SEL];
  assign pre_ratio = pre_decode(upper_control_r[csp_pkg::U_PRE_LO +: 4]);

  // Pin synchronisers; a change counts when stages two and three agree
  always_ff @(posedge core_clk) begin
    mck_s_r <= {mck_s_r[1:0], master_clock_input};
    bck_s_r <= {bck_s_r[1:0], bitclk_in};
    int_s_r <= {int_s_r[1:0], ext_int_n};
    rxs_s_r <= {rxs_s_r[1:0], ext_rx_sync_n};
    txs_s_r <= {txs_s_r[1:0], ext_tx_sync_n};
    rx0_s_r <= {rx0_s_r[0], ser_rx[0]};
    rx1_s_r <= {rx1_s_r[0], ser_rx[1]};
  end
  logic rx0_t_r, rx1_t_r;
  always_ff @(posedge core_clk) begin
    rx0_t_r <= rx0_s_r[1];
    rx1_t_r <= rx1_s_r[1];
    if (mck_s_r[2] == mck_s_r[1]) mck_st_r <= mck_s_r[2];
    if (bck_s_r[2] == bck_s_r[1]) bck_st_r <= bck_s_r[2];
    if (int_s_r[2] == int_s_r[1]) int_st_r <= int_s_r[2];
    if (rxs_s_r[2] == rxs_s_r[1]) rxs_st_r <= rxs_s_r[2];
    if (txs_s_r[2] == txs_s_r[1]) txs_st_r <= txs_s_r[2];
    if (rx0_t_r == rx0_s_r[1]) rx0_st_r <= rx0_t_r;
    if (rx1_t_r == rx1_s_r[1]) rx1_st_r <= rx1_t_r;
  end
  assign mck_rise = mck_s_r[2] == mck_s_r[1] && mck_s_r[2] && !mck_st_r;
  assign int_fire = int_s_r[2] == int_s_r[1] && !int_s_r[2] && int_st_r;
  assign rxs_fire = rxs_s_r[2] == rxs_s_r[1] && !rxs_s_r[2] && rxs_st_r;
  assign txs_fire = txs_s_r[2] == txs_s_r[1] && !txs_s_r[2] && txs_st_r;

  // Bit clock prescaler from master clock
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pre_cnt_r <= 5'h00;
      bitclk_gen_r <= 1'b0;
    end else if (mck_rise) begin
      if ({1'b0, pre_cnt_r} >= (pre_ratio >> 1) - 6'h01) begin
        pre_cnt_r <= 5'h00;
        bitclk_gen_r <= !bitclk_gen_r;
      end else begin
        pre_cnt_r <= pre_cnt_r + 5'h01;
      end
    end
  end
  assign bclk = lower_control_r[csp_pkg::B_CLK_IN] ? bck_st_r : bitclk_gen_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst) bclk_prev_r <= 1'b0;
    else bclk_prev_r <= bclk;
  end
  assign bclk_rise = bclk && !bclk_prev_r;
  assign bclk_fall = !bclk && bclk_prev_r;

  // Frame counter: period is divider value plus 2 bit clocks
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      frame_cnt_r <= 8'h00;
      pulse_cnt_r <= 4'h0;
      sync_r <= 1'b0;
    end else if (bclk_rise) begin
      if (frame_cnt_r >= upper_control_r[csp_pkg::U_DIV_LO +: 8] + 8'h01) begin
        frame_cnt_r <= 8'h00;
        sync_r <= 1'b1;
        pulse_cnt_r <= upper_control_r[csp_pkg::U_WIDTH] ?
                       csp_pkg::WIDE_PULSE_BITS - 4'h1 : 4'h0;
      end else begin
        frame_cnt_r <= frame_cnt_r + 8'h01;
        if (pulse_cnt_r != 4'h0) pulse_cnt_r <= pulse_cnt_r - 4'h1;
        else sync_r <= 1'b0;
      end
    end
  end
  assign frame_start = lower_control_r[csp_pkg::B_EXT_SYNC] ?
                       (txs_fire || rxs_fire) :
                       (bclk_rise && frame_cnt_r >= upper_control_r[7:0] + 8'h01);

  // Control registers; hardware set wins over a clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lower_control_r <= csp_pkg::LOWER_RST;
      upper_control_r <= csp_pkg::UPPER_RST;
    end else begin
      if (wr0) begin
        lower_control_r[15:4] <= port_wdata[15:4];
        lower_control_r[3:0] <= lower_control_r[3:0] & ~port_wdata[3:0];
      end
      if (int_fire) lower_control_r[csp_pkg::B_FLAG_INT] <= 1'b1;
      if (rxs_fire) lower_control_r[csp_pkg::B_FLAG_RXS] <= 1'b1;
      if (txs_fire) lower_control_r[csp_pkg::B_FLAG_TXS] <= 1'b1;
      if (bclk_rise && frame_cnt_r >= upper_control_r[7:0] + 8'h01) begin
        lower_control_r[csp_pkg::B_FLAG_SYN] <= 1'b1;
      end
      if (wr1 && !data_path) upper_control_r <= port_wdata[12:0];
    end
  end

  // Serial shifter, eight bits per frame on both channels
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bit_cnt_r <= 4'h0;
      active_r <= 1'b0;
      ser_tx <= 2'b00;
      for (int c = 0; c < 2; c++) begin
        tx_sh_r[c] <= '0;
        rx_sh_r[c] <= '0;
        rx_data_r[c] <= '0;
      end
    end else if (!lower_control_r[csp_pkg::B_SERIAL_EN]) begin
      active_r <= 1'b0;
      ser_tx <= 2'b00;
    end else if (frame_start) begin
      active_r <= 1'b1;
      bit_cnt_r <= 4'h0;
      // MSB leaves with the frame so all eight bits go out before the stop
      ser_tx <= {tx_data_r[1][SAMPLE_W-1], tx_data_r[0][SAMPLE_W-1]};
      tx_sh_r[0] <= tx_data_r[0] << 1;
      tx_sh_r[1] <= tx_data_r[1] << 1;
    end else if (active_r && bclk_rise) begin
      ser_tx <= {tx_sh_r[1][SAMPLE_W-1], tx_sh_r[0][SAMPLE_W-1]};
      tx_sh_r[0] <= tx_sh_r[0] << 1;
      tx_sh_r[1] <= tx_sh_r[1] << 1;
    end else if (active_r && bclk_fall) begin
      rx_sh_r[0] <= {rx_sh_r[0][SAMPLE_W-2:0], rx0_st_r};
      rx_sh_r[1] <= {rx_sh_r[1][SAMPLE_W-2:0], rx1_st_r};
      bit_cnt_r <= bit_cnt_r + 4'h1;
      if (bit_cnt_r == 4'(SAMPLE_W - 1)) begin
        active_r <= 1'b0;
        rx_data_r[0] <= {rx_sh_r[0][SAMPLE_W-2:0], rx0_st_r};
        rx_data_r[1] <= {rx_sh_r[1][SAMPLE_W-2:0], rx1_st_r};
      end
    end
  end

  // Port 1 data writes: transmit or parallel compander input
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_data_r[0] <= '0;
      tx_data_r[1] <= '0;
      par_result_r <= 16'h0000;
      ch_sel_r <= 1'b0;
    end else if (wr1 && data_path) begin
      if (lower_control_r[csp_pkg::B_SERIAL_EN]) begin
        tx_data_r[ch_sel_r] <= lower_control_r[csp_pkg::B_COMPRESS] ?
          encode(port_wdata[13:0], lower_control_r[csp_pkg::B_LAW]) : port_wdata[7:0];
        ch_sel_r <= !ch_sel_r;
      end else if (lower_control_r[csp_pkg::B_COMPRESS]) begin
        par_result_r <= {8'h00, encode(port_wdata[13:0], lower_control_r[csp_pkg::B_LAW])};
      end else if (lower_control_r[csp_pkg::B_EXPAND]) begin
        par_result_r <= {2'b00, decode(port_wdata[7:0], lower_control_r[csp_pkg::B_LAW])};
      end else begin
        par_result_r <= port_wdata;
      end
    end else if (rd1 && data_path && lower_control_r[csp_pkg::B_SERIAL_EN]) begin
      ch_sel_r <= !ch_sel_r;
    end
  end

  // Registered read data
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      port_rdata_r <= 16'h0000;
    end else if (port_rd && port_addr == 3'(csp_pkg::PORT_LOWER)) begin
      port_rdata_r <= lower_control_r;
    end else if (rd1 && !data_path) begin
      port_rdata_r <= {3'b000, upper_control_r};
    end else if (rd1 && lower_control_r[csp_pkg::B_SERIAL_EN]) begin
      port_rdata_r <= lower_control_r[csp_pkg::B_EXPAND] ?
        {2'b00, decode(rx_data_r[ch_sel_r], lower_control_r[csp_pkg::B_LAW])} :
        {8'h00, rx_data_r[ch_sel_r]};
    end else if (rd1) begin
      port_rdata_r <= par_result_r;
    end
  end

  // Registered pin outputs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bitclk_out <= 1'b0;
      bitclk_oe <= 1'b0;
      internal_sync_pulse <= 1'b0;
      user_flag_pin <= 1'b0;
    end else begin
      bitclk_out <= bitclk_gen_r;
      bitclk_oe <= !lower_control_r[csp_pkg::B_CLK_IN];
      internal_sync_pulse <= sync_r;
      user_flag_pin <= lower_control_r[csp_pkg::B_USER_FLAG];
    end
  end
  assign port_rdata = port_rdata_r;

  syn_flag_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (bclk_rise && !lower_control_r[csp_pkg::B_EXT_SYNC] &&
     frame_cnt_r >= upper_control_r[7:0] + 8'h01) |=> lower_control_r[3])
    else $error("sync flag not set at frame end");
  clr_flag_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr0 && port_wdata[0] && !int_fire) |=> !lower_control_r[0])
    else $error("flag not cleared by write of one");
  uflag_pin_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    ##1 user_flag_pin == $past(lower_control_r[csp_pkg::B_USER_FLAG]))
    else $error("user flag pin mismatch");
  upper_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr1 && data_path) |=> $stable(upper_control_r))
    else $error("upper control written in data mode");
  sync_width_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(sync_r) && !upper_control_r[csp_pkg::U_WIDTH] |-> pulse_cnt_r == 4'h0)
    else $error("narrow pulse width wrong");
  serial_off_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !lower_control_r[csp_pkg::B_SERIAL_EN] |=> !active_r)
    else $error("shifter active in parallel mode");
  par_enc_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr1 && data_path && !lower_control_r[11] && lower_control_r[12]) |=>
    par_result_r[15:8] == 8'h00)
    else $error("encode result too wide");
  clk_dir_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    lower_control_r[csp_pkg::B_CLK_IN] |=> !bitclk_oe)
    else $error("bit clock driven while input");
endmodule

// file: sim/csp_codec_model.sv
// Codec and highway model on the far side of the serial port
`timescale 1ns/1ps
module csp_codec_model #(
  parameter realtime HALF = 150.0,
  parameter logic [7:0] RX0 = 8'hC3,
  parameter logic [7:0] RX1 = 8'h5A
) (
  input wire logic run,
  input wire logic [1:0] ser_tx,
  output logic bitclk_in,
  output logic ext_rx_sync_n,
  output logic ext_tx_sync_n,
  output logic [1:0] ser_rx,
  output logic [7:0] tx_word0,
  output logic [7:0] tx_word1
);
  int unsigned cnt = 0;
  int unsigned b;
  logic [7:0] cap0 = 8'h00, cap1 = 8'h00;
  initial begin
    bitclk_in = 1'b0;
    ext_rx_sync_n = 1'b1;
    ext_tx_sync_n = 1'b1;
    ser_rx = 2'h1;
    tx_word0 = 8'h00;
    tx_word1 = 8'h00;
  end
  // Highway clock runs free once enabled
  always #(HALF) if (run) bitclk_in = ~bitclk_in;
  // One low sync bit every ten clocks, falling with the clock
  always @(negedge bitclk_in) begin
    cnt = (cnt + 1) % 10;
    ext_tx_sync_n = (cnt != 0);
    ext_rx_sync_n = (cnt != 0);
  end
  // Receive bits change on the rise, MSB just before the sync fall; transmit taken on the rise
  always @(posedge bitclk_in) begin
    if (cnt < 8) begin
      cap0 = {cap0[6:0], ser_tx[0]};
      cap1 = {cap1[6:0], ser_tx[1]};
    end
    if (cnt == 7) begin
      tx_word0 = cap0;
      tx_word1 = cap1;
    end
    b = (cnt == 9) ? 0 : cnt + 1;
    if (b < 8) ser_rx = {RX1[7 - b], RX0[7 - b]};
  end
endmodule

// file: sim/csp_top_tb_top.sv
// Testbench for the codec serial port block
`timescale 1ns/1ps
module csp_top_tb_top;
  typedef struct {logic [2:0] wa; logic [15:0] wd; logic [2:0] ra; logic [15:0] ex;
    logic [15:0] mk;} csp_row_s;
  logic core_clk = 0, sys_rst = 1, port_wr = 0, port_rd = 0, mclk = 0, run = 0;
  logic ext_int_n = 1;
  logic [2:0] port_addr = 3'h0;
  logic [15:0] port_wdata = 16'h0000, port_rdata, rv;
  logic bitclk_in, bitclk_out, bitclk_oe, rxs_n, txs_n, internal_sync_pulse, user_flag_pin;
  logic [1:0] ser_rx, ser_tx;
  logic [7:0] tx_word0, tx_word1;
  int n_errors = 0, n_compared = 0;
  realtime t0, t1;
  csp_row_s rows [4] = '{
    '{3'h0, 16'h0400, 3'h0, 16'h0400, 16'hFFF0},
    '{3'h1, 16'h1ABC, 3'h1, 16'h1ABC, 16'h1FFF},
    '{3'h2, 16'hFFFF, 3'h0, 16'h0400, 16'hFFF0},
    '{3'h3, 16'h0000, 3'h1, 16'h1ABC, 16'h1FFF}};
  always #2.5 core_clk = ~core_clk;
  always #20 mclk = ~mclk;
  csp_top u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .port_addr(port_addr),
    .port_wr(port_wr), .port_rd(port_rd), .port_wdata(port_wdata), .port_rdata(port_rdata),
    .master_clock_input(mclk), .bitclk_in(bitclk_in), .bitclk_out(bitclk_out),
    .bitclk_oe(bitclk_oe), .ext_int_n(ext_int_n), .ext_rx_sync_n(rxs_n),
    .ext_tx_sync_n(txs_n), .ser_rx(ser_rx), .ser_tx(ser_tx),
    .internal_sync_pulse(internal_sync_pulse), .user_flag_pin(user_flag_pin));
  csp_codec_model u_codec (.run(run), .ser_tx(ser_tx), .bitclk_in(bitclk_in),
    .ext_rx_sync_n(rxs_n), .ext_tx_sync_n(txs_n), .ser_rx(ser_rx),
    .tx_word0(tx_word0), .tx_word1(tx_word1));
  task fail(input string m);
    n_errors++;
    $display("FAIL %0t %s", $realtime, m);
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e, input logic [15:0] m, input string s);
    n_compared++;
    if ((g & m) !== (e & m)) fail(s);
  endtask
  task wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    port_addr <= a;
    port_wdata <= d;
    port_wr <= 1'b1;
    @(posedge core_clk);
    port_wr <= 1'b0;
  endtask
  task rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge core_clk);
    port_addr <= a;
    port_rd <= 1'b1;
    @(posedge core_clk);
    port_rd <= 1'b0;
    @(negedge core_clk);
    d = port_rdata;
  endtask
  function automatic logic sig(input int s);
    return s ? internal_sync_pulse : bitclk_out;
  endfunction
  task edge_t(input int s, output realtime t);
    logic p;
    int k;
    k = 0;
    do begin
      p = sig(s);
      @(negedge core_clk);
      k++;
    end while (!(p === 1'b0 && sig(s) === 1'b1) && k < 20000);
    if (k >= 20000) begin
      fail("no edge");
      wrap_up();
    end
    t = $realtime;
  endtask
  task period(input int s, input int n, input realtime e);
    edge_t(s, t0);
    edge_t(s, t0);
    repeat (n) edge_t(s, t1);
    n_compared++;
    if (t1 - t0 - e > 15.0 || t1 - t0 - e < -15.0) fail("period");
  endtask
  task width(input realtime e);
    int k;
    edge_t(1, t0);
    k = 0;
    while (internal_sync_pulse === 1'b1 && k < 5000) begin
      @(negedge core_clk);
      k++;
    end
    n_compared++;
    if (k * 5.0 - e > 10.0 || k * 5.0 - e < -10.0) fail("width");
  endtask
  function automatic int ratio(input logic [3:0] c);
    casez (c)
      4'b0000: return 32;
      4'b0001: return 28;
      4'b001?: return 24;
      4'b01??: return 20;
      4'b1000: return 16;
      4'b1001: return 14;
      4'b101?: return 12;
      default: return 10;
    endcase
  endfunction
  task wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(3'h0, rv);
    chk(rv, 16'h0000, 16'hFFF0, "lower reset");
    rd(3'h1, rv);
    chk(rv, 16'h0000, 16'h1FFF, "upper reset");
    chk({15'h0000, user_flag_pin}, 16'h0000, 16'h0001, "pin reset");
    $display("Test reset done");
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra, rv);
      chk(rv, rows[i].ex, rows[i].mk, "row");
    end
    chk({15'h0000, user_flag_pin}, 16'h0001, 16'h0001, "pin set");
    $display("Test register rows done");
    wr(3'h0, 16'h0000);
    repeat (2) @(negedge core_clk);
    chk({15'h0000, user_flag_pin}, 16'h0000, 16'h0001, "pin clear");
    chk({15'h0000, bitclk_oe}, 16'h0001, 16'h0001, "clock out");
    for (int c = 0; c < 16; c++) begin
      wr(3'h1, {4'h0, c[3:0], 8'h08});
      period(0, 4, 4 * ratio(c[3:0]) * 40.0);
    end
    $display("Test prescaler done");
    wr(3'h1, 16'h0C08);
    period(1, 2, 8000.0);
    width(400.0);
    wr(3'h1, 16'h1C08);
    width(3200.0);
    rd(3'h0, rv);
    chk(rv, 16'h0008, 16'h0008, "frame flag");
    wr(3'h0, 16'h0000);
    rd(3'h0, rv);
    chk(rv, 16'h0008, 16'h0008, "zero keeps");
    edge_t(1, t0);
    repeat (4) @(posedge core_clk);
    wr(3'h0, 16'h0008);
    rd(3'h0, rv);
    chk(rv, 16'h0000, 16'h0008, "one clears");
    @(posedge core_clk);
    ext_int_n <= 1'b0;
    repeat (10) @(negedge core_clk);
    rd(3'h0, rv);
    chk(rv, 16'h0001, 16'h0001, "int flag");
    wr(3'h0, 16'h0001);
    rd(3'h0, rv);
    chk(rv, 16'h0000, 16'h0001, "int clears");
    $display("Test sync and flags done");
    wr(3'h0, 16'h0100);
    wr(3'h1, 16'h0055);
    rd(3'h1, rv);
    chk(rv, 16'h0055, 16'h00FF, "raw data");
    wr(3'h0, 16'h1100);
    wr(3'h1, 16'h0021);
    rd(3'h1, rv);
    chk(rv, 16'h00FF, 16'h00FF, "mu encode");
    wr(3'h0, 16'h2100);
    wr(3'h1, 16'h00FF);
    rd(3'h1, rv);
    chk(rv, 16'h0021, 16'h1FFF, "mu decode");
    wr(3'h0, 16'h5100);
    wr(3'h1, 16'h0000);
    rd(3'h1, rv);
    chk(rv, 16'h0055, 16'h007F, "a-law encode");
    wr(3'h0, 16'h0000);
    rd(3'h1, rv);
    chk(rv, 16'h1C08, 16'h1FFF, "refused");
    $display("Test parallel path done");
    wr(3'h1, 16'h0C08);
    wr(3'h0, 16'h8000);
    run <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk({15'h0000, bitclk_oe}, 16'h0000, 16'h0001, "clock in");
    period(1, 2, 6000.0);
    rd(3'h0, rv);
    chk(rv, 16'h0006, 16'h0006, "ext sync");
    $display("Test external clock done");
    wr(3'h0, 16'h8B00);
    wr(3'h1, 16'h00A5);
    wr(3'h0, 16'h9B00);
    wr(3'h1, 16'h0021);
    repeat (1500) @(posedge core_clk);
    chk({8'h00, tx_word0}, 16'h00A5, 16'h00FF, "serial tx0");
    chk({8'h00, tx_word1}, 16'h00FF, 16'h00FF, "serial tx1");
    rd(3'h1, rv);
    chk(rv, 16'h00C3, 16'h00FF, "serial rx0");
    wr(3'h0, 16'hAB00);
    rd(3'h1, rv);
    chk(rv, 16'h00AC, 16'h1FFF, "serial rx1");
    $display("Test serial path done");
    wrap_up();
  end
  initial begin
    #400000;
    fail("timeout");
    wrap_up();
  end
endmodule
